// ==== rtl/dbd_cfg.svh ====
// Purpose: Constants for the DRAM bank decode and reset block
// Assumes: 125 MHz system clock
// Notes:   Field positions, reset values and timing counts
`ifndef DBD_CFG_SVH
`define DBD_CFG_SVH
`define DBD_BASE_MSB 31
`define DBD_BASE_LSB 17
`define DBD_FIELD_W 15
`define DBD_PERIOD_W 12
`define DBD_TIMING_W 16
`define DBD_PERIOD_RST 12'h000
`define DBD_TIMING_RST 16'h0000
`define DBD_ALT_MUX_BIT 15
`define DBD_RAS_W 2
`define DBD_CAS_W 2
`define DBD_PHASE_W 4
`define DBD_REF_UNIT 8'h40
`define DBD_REF_UNIT_W 8
`endif

// ==== rtl/dbd_pkg.sv ====
// Purpose: Types for the DRAM bank decode and reset block
// Assumes: Nothing beyond the cfg header
// Notes:   Port size and cycle state encodings
`default_nettype none
package dbd_pkg;
   typedef enum logic [1:0] {
      DBD_PS_32 = 2'b00,
      DBD_PS_8 = 2'b01,
      DBD_PS_16 = 2'b10,
      DBD_PS_RSV = 2'b11
   } dbd_port_e;
   typedef enum logic [2:0] {
      DBD_IDLE = 3'b000,
      DBD_RAS = 3'b001,
      DBD_CAS = 3'b010,
      DBD_PRE = 3'b011,
      DBD_REF_CAS = 3'b100,
      DBD_REF_RAS = 3'b101
   } dbd_state_e;
endpackage
`default_nettype wire

// ==== rtl/dbd_ctrl.sv ====
// Purpose: DRAM bank decode, address mux, lane strobes and reset handling
// Assumes: Transfer request is a one-cycle pulse from the bus controller
// Notes:   Refresh timing is a simple counter; page modes not modelled
//
// Behaviour
// - Core transfers get row then column address driven on address pins.
// - Alternate master transfers multiplex only when alt_master_mux_en set.
// - 32-bit port on D31:0, 16-bit on D31:16, 8-bit on D31:24.
// - Master reset reinitialises period, timing, refresh timer and sequencer, and halts all.
// - During master reset refresh counter stops and no refresh issues.
// - Master reset cuts off any transfer or refresh immediately.
// - Reset plus high-z is master reset; reset alone is normal reset.
// - Normal reset keeps period, timing and refresh running.
// - Watchdog resets act as normal resets.
// - Master reset clears refresh period and waveform timing to zero.
// - Two banks configured independently; one waveform timing for both.
// - Bank matches when all unmasked base bits equal address bits.
// - Base and mask fields cover address bits 31 down to 17.
// - All mask bits clear gives a 128 kbyte bank.
// - Only address bits 27:0 reach pins; 27:24 only when pin-assigned.
// - Column strobe 0..3 gate lanes D31:24, D23:16, D15:8, D7:0.
// - Write strobe asserted on writes, negated on reads and refresh.
// - Bank 0 wins over bank 1; no match means no strobes.
`timescale 1ns/10ps
`include "dbd_cfg.svh"
`default_nettype none
module dbd_ctrl
   import dbd_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic reset_in_pin_n_i,
   input wire logic high_z_pin_n_i,
   input wire logic wdog_reset_i,
   input wire logic cfg_we_i,
   input wire logic [`DBD_PERIOD_W-1:0] refresh_period_reg_i,
   input wire logic [`DBD_TIMING_W-1:0] waveform_timing_reg_i,
   input wire logic [`DBD_FIELD_W-1:0] bank0_base_i,
   input wire logic [`DBD_FIELD_W-1:0] bank0_mask_i,
   input wire logic [1:0] bank0_port_i,
   input wire logic [`DBD_FIELD_W-1:0] bank1_base_i,
   input wire logic [`DBD_FIELD_W-1:0] bank1_mask_i,
   input wire logic [1:0] bank1_port_i,
   input wire logic [3:0] pin_assign_reg_i,
   input wire logic xfer_req_i,
   input wire logic xfer_alt_i,
   input wire logic xfer_write_i,
   input wire logic [31:0] xfer_addr_i,
   input wire logic [1:0] xfer_size_i,
   output logic [27:0] addr_o,
   output logic [1:0] ras_n_o,
   output logic [3:0] cas_n_o,
   output logic dram_write_strobe_n_o,
   output logic xfer_hit_o,
   output logic xfer_done_o,
   output logic refresh_active_o
);
   // ------------------------------------------------------------
   // Reset qualification
   // ------------------------------------------------------------
   logic rst_s1, rst_s2, hiz_s1, hiz_s2;
   logic next_master, next_normal;
   logic master_rst, normal_rst;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
         hiz_s1 <= 1'b0;
         hiz_s2 <= 1'b0;
      end else begin
         rst_s1 <= ~reset_in_pin_n_i;
         rst_s2 <= rst_s1;
         hiz_s1 <= ~high_z_pin_n_i;
         hiz_s2 <= hiz_s1;
      end
   end
   always_comb begin
      next_master = rst_s2 & hiz_s2;
      // Watchdog never touches refresh state
      next_normal = (rst_s2 & ~hiz_s2) | wdog_reset_i;
   end
   // Power-on via rstn_i counts as master reset
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         master_rst <= 1'b1;
         normal_rst <= 1'b0;
      end else begin
         master_rst <= next_master;
         normal_rst <= next_normal;
      end
   end

   // ------------------------------------------------------------
   // Refresh and timing registers
   // ------------------------------------------------------------
   logic [`DBD_PERIOD_W-1:0] period, next_period;
   logic [`DBD_TIMING_W-1:0] timing, next_timing;
   always_comb begin
      next_period = period;
      next_timing = timing;
      if (master_rst) begin
         next_period = `DBD_PERIOD_RST;
         next_timing = `DBD_TIMING_RST;
      end else if (cfg_we_i && !normal_rst) begin
         // Normal reset leaves both untouched
         next_period = refresh_period_reg_i;
         next_timing = waveform_timing_reg_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         period <= `DBD_PERIOD_RST;
         timing <= `DBD_TIMING_RST;
      end else begin
         period <= next_period;
         timing <= next_timing;
      end
   end

   // ------------------------------------------------------------
   // Refresh request timer
   // ------------------------------------------------------------
   // Interval = (4096 - period) units; zero is the slowest rate
   // Compare is >= so a shortened period takes hold at once
   logic [`DBD_REF_UNIT_W-1:0] unit_cnt, next_unit_cnt;
   logic [`DBD_PERIOD_W-1:0] ref_cnt, next_ref_cnt;
   logic ref_pend, next_ref_pend;
   logic ref_take;
   always_comb begin
      next_unit_cnt = unit_cnt;
      next_ref_cnt = ref_cnt;
      next_ref_pend = ref_pend;
      if (master_rst) begin
         // Counter halted, nothing pending
         next_unit_cnt = '0;
         next_ref_cnt = '0;
         next_ref_pend = 1'b0;
      end else begin
         // Clear first so an expiry in the same cycle is kept
         if (ref_take) begin
            next_ref_pend = 1'b0;
         end
         // Keeps counting through normal reset
         if (unit_cnt == `DBD_REF_UNIT - 8'h01) begin
            next_unit_cnt = '0;
            if (ref_cnt >= ~period) begin
               next_ref_cnt = '0;
               next_ref_pend = 1'b1;
            end else begin
               next_ref_cnt = ref_cnt + 12'h001;
            end
         end else begin
            next_unit_cnt = unit_cnt + 8'h01;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         unit_cnt <= '0;
         ref_cnt <= '0;
         ref_pend <= 1'b0;
      end else begin
         unit_cnt <= next_unit_cnt;
         ref_cnt <= next_ref_cnt;
         ref_pend <= next_ref_pend;
      end
   end

   // ------------------------------------------------------------
   // Bank decode
   // ------------------------------------------------------------
   logic [`DBD_FIELD_W-1:0] addr_hi;
   logic hit0, hit1;
   always_comb begin
      addr_hi = xfer_addr_i[`DBD_BASE_MSB:`DBD_BASE_LSB];
      // Masked bits drop out; zero mask leaves a 128 kbyte window
      hit0 = ((addr_hi ^ bank0_base_i) & ~bank0_mask_i) == '0;
      hit1 = ((addr_hi ^ bank1_base_i) & ~bank1_mask_i) == '0;
   end

   // ------------------------------------------------------------
   // Cycle sequencer
   // ------------------------------------------------------------
   dbd_state_e state, next_state;
   logic [`DBD_PHASE_W-1:0] ph_cnt, next_ph_cnt;
   logic bank, next_bank;
   logic mux_on, next_mux_on;
   logic wr, next_wr;
   logic [1:0] port, next_port;
   logic [1:0] size, next_size;
   logic [27:0] lat_addr, next_lat_addr;
   logic [`DBD_PHASE_W-1:0] ras_len, cas_len;
   always_comb begin
      // One waveform timing shared by both banks
      ras_len = {2'b00, timing[3:2]} + 4'h1;
      cas_len = {2'b00, timing[1:0]} + 4'h1;
   end
   always_comb begin
      next_state = state;
      next_ph_cnt = ph_cnt;
      next_bank = bank;
      next_mux_on = mux_on;
      next_wr = wr;
      next_port = port;
      next_size = size;
      next_lat_addr = lat_addr;
      ref_take = 1'b0;
      if (master_rst) begin
         next_state = DBD_IDLE;
         next_ph_cnt = '0;
      end else begin
         case (state)
            DBD_IDLE: begin
               next_ph_cnt = '0;
               if (ref_pend) begin
                  ref_take = 1'b1;
                  next_state = DBD_REF_CAS;
               end else if (xfer_req_i && !normal_rst && (hit0 || hit1)) begin
                  // Decode uses the registers seen at request
                  next_bank = ~hit0;
                  next_port = hit0 ? bank0_port_i : bank1_port_i;
                  // Core always muxed, alt master only if enabled
                  next_mux_on = ~xfer_alt_i |
                     timing[`DBD_ALT_MUX_BIT];
                  next_wr = xfer_write_i;
                  next_size = xfer_size_i;
                  next_lat_addr = xfer_addr_i[27:0];
                  next_state = DBD_RAS;
               end
            end
            DBD_RAS: begin
               next_ph_cnt = ph_cnt + 4'h1;
               if (ph_cnt + 4'h1 >= ras_len) begin
                  next_ph_cnt = '0;
                  next_state = DBD_CAS;
               end
            end
            DBD_CAS: begin
               next_ph_cnt = ph_cnt + 4'h1;
               if (ph_cnt + 4'h1 >= cas_len) begin
                  next_ph_cnt = '0;
                  next_state = DBD_PRE;
               end
            end
            DBD_PRE: begin
               next_state = DBD_IDLE;
            end
            DBD_REF_CAS: begin
               next_state = DBD_REF_RAS;
            end
            DBD_REF_RAS: begin
               next_ph_cnt = ph_cnt + 4'h1;
               if (ph_cnt + 4'h1 >= ras_len) begin
                  next_ph_cnt = '0;
                  next_state = DBD_PRE;
               end
            end
            default: begin
               next_state = DBD_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= DBD_IDLE;
         ph_cnt <= '0;
         bank <= 1'b0;
         mux_on <= 1'b1;
         wr <= 1'b0;
         port <= 2'b00;
         size <= 2'b00;
         lat_addr <= '0;
      end else begin
         state <= next_state;
         ph_cnt <= next_ph_cnt;
         bank <= next_bank;
         mux_on <= next_mux_on;
         wr <= next_wr;
         port <= next_port;
         size <= next_size;
         lat_addr <= next_lat_addr;
      end
   end

   // ------------------------------------------------------------
   // Lane strobes and pin outputs
   // ------------------------------------------------------------
   logic [3:0] lanes;
   logic [27:0] col_addr, addr_pins, next_addr;
   logic [1:0] next_ras_n;
   logic [3:0] next_cas_n;
   logic next_dw_n, next_hit, next_done, next_ref_act;
   always_comb begin
      // Narrow ports sit on upper lanes, strobe 0 = D31:24
      case (port)
         DBD_PS_8: lanes = 4'b0001;
         DBD_PS_16: lanes = lat_addr[0] ? 4'b0010 :
            (size == 2'b01 ? 4'b0001 : 4'b0011);
         default: begin
            case (size)
               2'b01: lanes = 4'b0001 << lat_addr[1:0];
               2'b10: lanes = lat_addr[1] ? 4'b1100 : 4'b0011;
               default: lanes = 4'b1111;
            endcase
         end
      endcase
      // Column bits shifted up by the row width; 9-bit page assumed
      col_addr = {lat_addr[27:18], lat_addr[8:0], lat_addr[8:0]};
      addr_pins = (state == DBD_CAS && mux_on) ? col_addr : lat_addr;
      // Upper pins follow pin assignment
      next_addr = {addr_pins[27:24] & pin_assign_reg_i,
         addr_pins[23:0]};
      next_ras_n = 2'b11;
      next_cas_n = 4'hF;
      next_dw_n = 1'b1;
      next_hit = 1'b0;
      next_done = 1'b0;
      next_ref_act = 1'b0;
      case (state)
         DBD_RAS: begin
            next_ras_n[bank] = 1'b0;
            next_dw_n = ~wr;
            next_hit = 1'b1;
         end
         DBD_CAS: begin
            next_ras_n[bank] = 1'b0;
            next_cas_n = ~lanes;
            next_dw_n = ~wr;
            next_hit = 1'b1;
            next_done = (ph_cnt + 4'h1 >= cas_len);
         end
         DBD_REF_CAS: begin
            next_cas_n = 4'h0;
            next_ref_act = 1'b1; // Write strobe stays high
         end
         DBD_REF_RAS: begin
            next_cas_n = 4'h0;
            next_ras_n = 2'b00;
            next_ref_act = 1'b1;
         end
         default: begin
            next_ras_n = 2'b11; // No match, no strobes
         end
      endcase
      if (master_rst) begin
         next_ras_n = 2'b11; // Cut off at once
         next_cas_n = 4'hF;
         next_dw_n = 1'b1;
         next_hit = 1'b0;
         next_done = 1'b0;
         next_ref_act = 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_o <= '0;
         ras_n_o <= 2'b11;
         cas_n_o <= 4'hF;
         dram_write_strobe_n_o <= 1'b1;
         xfer_hit_o <= 1'b0;
         xfer_done_o <= 1'b0;
         refresh_active_o <= 1'b0;
      end else begin
         addr_o <= next_addr;
         ras_n_o <= next_ras_n;
         cas_n_o <= next_cas_n;
         dram_write_strobe_n_o <= next_dw_n;
         xfer_hit_o <= next_hit;
         xfer_done_o <= next_done;
         refresh_active_o <= next_ref_act;
      end
   end
endmodule
`default_nettype wire

// ==== bench/dbd_ctrl_sva.sv ====
// Purpose: Port checks for the DRAM bank decode block
// Assumes: Waveform timing bits 3:0 left at zero while transfers run
// Notes:   Bound to every dbd_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module dbd_ctrl_sva (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic reset_in_pin_n_i,
   input wire logic high_z_pin_n_i,
   input wire logic [3:0] pin_assign_reg_i,
   input wire logic [27:0] addr_o,
   input wire logic [1:0] ras_n_o,
   input wire logic [3:0] cas_n_o,
   input wire logic dram_write_strobe_n_o,
   input wire logic xfer_hit_o,
   input wire logic xfer_done_o,
   input wire logic refresh_active_o
);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   logic mrst;
   // Two-flop sync, qualify flop and output flop: five samples
   assign mrst = !reset_in_pin_n_i && !high_z_pin_n_i;
   property p_halt;
      mrst [*5] |-> ras_n_o == 2'b11 && cas_n_o == 4'hf;
   endproperty
   a_halt: assert property (p_halt) else $error("strobe live");
   property p_no_ref;
      mrst [*5] |-> !refresh_active_o;
   endproperty
   a_no_ref: assert property (p_no_ref) else $error("refresh run");
   property p_wr_ref;
      refresh_active_o |-> dram_write_strobe_n_o;
   endproperty
   a_wr_ref: assert property (p_wr_ref) else $error("refresh write");
   property p_wr_xfer;
      !dram_write_strobe_n_o |-> ras_n_o != 2'b11 && xfer_hit_o;
   endproperty
   a_wr_xfer: assert property (p_wr_xfer) else $error("stray write");
   property p_one_bank;
      !refresh_active_o |-> ras_n_o != 2'b00;
   endproperty
   a_one_bank: assert property (p_one_bank) else $error("two banks");
   property p_ras_hit;
      ras_n_o != 2'b11 && !refresh_active_o |-> xfer_hit_o;
   endproperty
   a_ras_hit: assert property (p_ras_hit) else $error("row on miss");
   property p_cas_row;
      cas_n_o != 4'hf && !refresh_active_o |-> $past(ras_n_o) != 2'b11;
   endproperty
   a_cas_row: assert property (p_cas_row) else $error("col, no row");
   property p_done;
      xfer_done_o |-> cas_n_o != 4'hf ##1 ras_n_o == 2'b11 && !xfer_done_o;
   endproperty
   a_done: assert property (p_done) else $error("done misplaced");
   property p_pins;
      1'b1 |-> (addr_o[27:24] & ~$past(pin_assign_reg_i)) == 4'h0;
   endproperty
   a_pins: assert property (p_pins) else $error("pin not assigned");
endmodule
bind dbd_ctrl dbd_ctrl_sva dbd_ctrl_sva_inst (.clk_sys_i, .rstn_i,
   .reset_in_pin_n_i, .high_z_pin_n_i, .pin_assign_reg_i, .addr_o,
   .ras_n_o, .cas_n_o, .dram_write_strobe_n_o, .xfer_hit_o, .xfer_done_o,
   .refresh_active_o);
`default_nettype wire

// ==== bench/dbd_dram_model.sv ====
// Purpose: Two-bank asynchronous DRAM seen from its strobes
// Assumes: Strobes sampled on the system clock
// Notes:   No data bus on the block, so only lanes, write and refresh count are recorded
`timescale 1ns/10ps
`default_nettype none
module dbd_dram_model (
   input wire logic clk_sys_i,
   input wire logic [1:0] ras_n_i,
   input wire logic [3:0] cas_n_i,
   input wire logic we_n_i,
   output var int ref_cnt,
   output logic [3:0] lanes,
   output logic wr
);
   // ---------------------------------------------------------------
   // Strobe decode
   // ---------------------------------------------------------------
   logic [3:0] cas_q = 4'hf;
   initial ref_cnt = 0;
   always @(posedge clk_sys_i) begin
      // Column strobe with rows idle is a refresh
      if (cas_q == 4'hf && cas_n_i != 4'hf && ras_n_i == 2'b11)
         ref_cnt <= ref_cnt + 1;
      // Lane 0 is D31:24, narrow ports sit high
      if (cas_q == 4'hf && cas_n_i != 4'hf && ras_n_i != 2'b11) begin
         lanes <= ~cas_n_i;
         wr <= !we_n_i;
      end
      cas_q <= cas_n_i;
   end
endmodule
`default_nettype wire

// ==== bench/tb_dbd_ctrl.sv ====
// Purpose: Self-checking bench for the DRAM bank decode block
// Assumes: Timing register bits 3:0 zero while transfers are checked
// Notes:   Refresh period kept long so it never collides with a transfer
`timescale 1ns/10ps
`default_nettype none
module tb_dbd_ctrl;
   import dbd_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and checks
   // ---------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic reset_in_pin_n_i = 1'b1;
   logic high_z_pin_n_i = 1'b1;
   logic wdog_reset_i = 1'b0;
   logic cfg_we_i = 1'b0;
   logic [11:0] refresh_period_reg_i = 12'h000;
   logic [15:0] waveform_timing_reg_i = 16'h0000;
   logic [14:0] bank0_base_i = 15'h0000;
   logic [14:0] bank0_mask_i = 15'h0000;
   logic [14:0] bank1_base_i = 15'h7fff;
   logic [14:0] bank1_mask_i = 15'h0000;
   logic [1:0] bank0_port_i = 2'b00;
   logic [1:0] bank1_port_i = 2'b00;
   logic [3:0] pin_assign_reg_i = 4'hf;
   logic xfer_req_i = 1'b0;
   logic xfer_alt_i = 1'b0;
   logic xfer_write_i = 1'b0;
   logic [31:0] xfer_addr_i = 32'h0000_0000;
   logic [1:0] xfer_size_i = 2'b00;
   logic [27:0] addr_o, row, col;
   logic [1:0] ras_n_o;
   logic [3:0] cas_n_o, lanes;
   logic dram_write_strobe_n_o, xfer_hit_o, xfer_done_o, refresh_active_o, wr;
   int ref_cnt, err_count = 0, compares = 0;
   dbd_ctrl dbd_ctrl_inst (.clk_sys_i, .rstn_i, .reset_in_pin_n_i,
      .high_z_pin_n_i, .wdog_reset_i, .cfg_we_i, .refresh_period_reg_i,
      .waveform_timing_reg_i, .bank0_base_i, .bank0_mask_i, .bank0_port_i,
      .bank1_base_i, .bank1_mask_i, .bank1_port_i, .pin_assign_reg_i,
      .xfer_req_i, .xfer_alt_i, .xfer_write_i, .xfer_addr_i, .xfer_size_i,
      .addr_o, .ras_n_o, .cas_n_o, .dram_write_strobe_n_o, .xfer_hit_o,
      .xfer_done_o, .refresh_active_o);
   dbd_dram_model dbd_dram_model_inst (.clk_sys_i, .ras_n_i(ras_n_o),
      .cas_n_i(cas_n_o), .we_n_i(dram_write_strobe_n_o), .ref_cnt, .lanes,
      .wr);
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   task automatic wrap_up();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // Inputs move 1 ns after the rising edge, outputs are settled then
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic cfg(input logic [11:0] p, input logic [15:0] t);
      refresh_period_reg_i = p;
      waveform_timing_reg_i = t;
      cfg_we_i = 1'b1;
      cyc(1);
      cfg_we_i = 1'b0;
      cyc(1);
   endtask
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [1:0] s, input int bank);
      int n;
      logic [1:0] eb;
      eb = ~(2'b01 << bank);
      for (n = 0; n < 50 && refresh_active_o !== 1'b0; n++) cyc(1);
      chk(refresh_active_o, 1'b0, "refresh wait");
      xfer_addr_i = a;
      xfer_write_i = w;
      xfer_size_i = s;
      xfer_req_i = 1'b1;
      cyc(1);
      xfer_req_i = 1'b0;
      for (n = 0; n < 6 && ras_n_o === 2'b11; n++) cyc(1);
      chk(ras_n_o, (bank > 1) ? 2'b11 : eb, "bank");
      if (bank > 1)
         return;
      chk(xfer_hit_o, 1'b1, "hit");
      chk(dram_write_strobe_n_o, !w, "write strobe");
      row = addr_o;
      cyc(1);
      chk(xfer_done_o, 1'b1, "done");
      col = addr_o;
      cyc(1);
   endtask
   task automatic t_lanes();
      logic [3:0] e;
      logic [1:0] sz;
      bank0_base_i = 15'h0200;
      bank0_mask_i = 15'h007f;
      for (int p = 0; p < 3; p++) begin
         for (int s = 0; s < 3; s++) begin
            for (int a = 0; a < 4; a++) begin
               if ((s == 1 && a[0]) || (s == 2 && a != 0))
                  continue;
               sz = (s == 0) ? 2'b01 : (s == 1) ? 2'b10 : 2'b00;
               bank0_port_i = p[1:0];
               e = (s == 0) ? 4'b0001 << a : (s == 1) ? 4'b0011 << a : 4'hf;
               if (p == 1)
                  e = 4'b0001;
               if (p == 2)
                  e = (s == 0) ? 4'b0001 << a[0] : 4'b0011;
               xfer(32'h0400_0000 + a, a[0], sz, 0);
               chk(lanes, e, "lanes");
               chk(wr, a[0], "dram write");
            end
         end
      end
   endtask
   task automatic t_decode();
      logic [31:0] ad [7] = '{32'h0400_0000, 32'h0401_fffc, 32'h0402_0000,
         32'h0500_0000, 32'h050e_0000, 32'h0510_0000, 32'h8400_0000};
      int bk [7] = '{0, 0, 2, 1, 1, 2, 2};
      bank0_mask_i = 15'h0000;
      bank1_base_i = 15'h0280;
      bank1_mask_i = 15'h0007;
      for (int i = 0; i < 7; i++)
         xfer(ad[i], 1'b0, 2'b00, bk[i]);
      bank1_base_i = 15'h0200;
      bank1_mask_i = 15'h0000;
      xfer(32'h0400_0000, 1'b1, 2'b00, 0);
      bank0_base_i = 15'h0201;
      xfer(32'h0400_0000, 1'b1, 2'b00, 1);
   endtask
   task automatic t_addr();
      logic [31:0] a;
      a = 32'h0f00_01a5;
      bank0_base_i = 15'h0000;
      bank0_mask_i = 15'h7fff;
      pin_assign_reg_i = 4'b0101;
      xfer(a, 1'b0, 2'b01, 0);
      chk(row, {a[27:24] & 4'b0101, a[23:0]}, "row");
      chk(col[17:9], a[8:0], "core col");
      xfer_alt_i = 1'b1;
      xfer(a, 1'b0, 2'b01, 0);
      chk(col[17:9], a[17:9], "alt col unmuxed");
      cfg(12'h000, 16'h8000);
      xfer(a, 1'b0, 2'b01, 0);
      chk(col[17:9], a[8:0], "alt col muxed");
      xfer_alt_i = 1'b0;
   endtask
   task automatic t_resets();
      int c;
      cfg(12'hffe, 16'h000f);
      reset_in_pin_n_i = 1'b0;
      c = ref_cnt;
      cyc(300);
      chk(ref_cnt - c >= 2, 1'b1, "normal reset refresh");
      reset_in_pin_n_i = 1'b1;
      wdog_reset_i = 1'b1;
      c = ref_cnt;
      cyc(300);
      chk(ref_cnt - c >= 2, 1'b1, "watchdog refresh");
      wdog_reset_i = 1'b0;
      cyc(2);
      cfg(12'hfff, 16'h000f);
      reset_in_pin_n_i = 1'b0;
      high_z_pin_n_i = 1'b0;
      cyc(5);
      c = ref_cnt;
      cyc(300);
      chk(ref_cnt - c, 0, "master reset refresh");
      chk({ras_n_o, cas_n_o}, 6'h3f, "master reset strobes");
      reset_in_pin_n_i = 1'b1;
      high_z_pin_n_i = 1'b1;
      c = ref_cnt;
      cyc(150);
      chk(ref_cnt - c, 0, "period cleared");
      cyc(4);
      xfer(32'h0400_0000, 1'b1, 2'b00, 0);
   endtask
   initial begin
      cyc(10);
      rstn_i = 1'b1;
      cyc(3);
      cfg(12'h000, 16'h0000);
      t_lanes();
      t_decode();
      t_addr();
      t_resets();
      wrap_up();
   end
endmodule
`default_nettype wire
